// ---- src/pia_defines.svh ----
`ifndef PIA_DEFINES_SVH
`define PIA_DEFINES_SVH

// register indices on the management interface
`define PIA_REG_BASIC_STATUS 5'h01
`define PIA_REG_IDENT_HIGH 5'h02
`define PIA_REG_IDENT_LOW 5'h03
`define PIA_REG_ADVERT 5'h04
`define PIA_REG_PHY_CONTROL 5'h10

// management frame fields
`define PIA_PHY_ADDR 5'h01
`define PIA_OP_READ 2'h2
`define PIA_OP_WRITE 2'h1
`define PIA_PREAMBLE_ONES 6'h20
`define PIA_ADDR_BITS 5'h0a
`define PIA_DATA_LAST 5'h0f

// basic status field positions
`define PIA_BS_MORE_REGS 0
`define PIA_BS_JABBER 1
`define PIA_BS_AN_DONE 5

// advertisement field positions
`define PIA_AD_NEXT_PAGE 15
`define PIA_AD_RSVD14 14
`define PIA_AD_FAR_FAULT 13
`define PIA_AD_RSVD12 12
`define PIA_AD_ASYM 11
`define PIA_AD_PAUSE 10
`define PIA_AD_FOUR_PAIR 9
`define PIA_AD_FAST_FD 8
`define PIA_AD_FAST_HD 7
`define PIA_AD_TEN_FD 6
`define PIA_AD_TEN_HD 5
`define PIA_AD_SEL_HI 4

// phy control field positions
`define PIA_PC_TX_PAUSE 13
`define PIA_PC_RX_PAUSE 12

// reset values
`define PIA_SELECTOR_RST 5'h01

// identity defaults, values are arbitrary
`define PIA_ORG_HIGH_DEF 16'h1234
`define PIA_ORG_LOW_DEF 6'h15
`define PIA_MODEL_DEF 6'h2a
`define PIA_REV_DEF 4'h3

`endif

// ---- src/pia_pkg.sv ----
package pia_pkg;
  // management frame engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_OPCODE = 3'b010,
    ST_ADDR = 3'b011,
    ST_TURN = 3'b100,
    ST_DATA = 3'b101
  } pia_state_t;
endpackage

// ---- src/pia_sync.sv ----
// two-stage synchroniser, one stage pair per bit
module pia_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,           // system clock
  input wire logic [WIDTH-1:0] async_i, // inputs from pins
  output logic [WIDTH-1:0] sync_o       // synchronised copy
);
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      logic stage1; // first stage, read only by the second
      // no reset: data path only, settles within two edges
      always_ff @(posedge clk_sys_i) begin
        stage1 <= async_i[gi];
        sync_o[gi] <= stage1;
      end
    end
  endgenerate
endmodule

// ---- src/pia_regs.sv ----
`include "pia_defines.svh"
//
// Contract
// - jabber bit latches, clears on read/reset
// - basic status bit 0 always reads one
// - identity is org code, model, revision
// - ident one holds org bits 3..18
// - ident two bits 15:10 hold org 19..24
// - ident two bits 9:4 hold model number
// - ident two bits 3:0 hold revision
// - next page wish bit rw, reset zero
// - far fault advert bit rw, reset zero
// - bit 14 ignores writes; bit 12 zero
// - asym pause advert bit rw, reset zero
// - symmetric pause bit rw, reset zero
// - pause resolution shown in phy control 13:12
// - four pair bit reads zero always
// - speed/duplex advert bits rw, strap reset
// - basic status bit 5 shows negotiation done
module pia_regs #(
  parameter logic [15:0] ORG_HIGH = `PIA_ORG_HIGH_DEF, // arbitrary value
  parameter logic [5:0] ORG_LOW = `PIA_ORG_LOW_DEF,    // arbitrary value
  parameter logic [5:0] MODEL = `PIA_MODEL_DEF,        // arbitrary value
  parameter logic [3:0] REV = `PIA_REV_DEF             // arbitrary value
) (
  input wire logic clk_sys_i,          // 20 MHz system clock
  input wire logic rst_i,              // synchronous reset, high
  input wire logic mdc_i,              // management clock pin
  input wire logic mdio_i,             // management data pin level
  output logic mdio_o,                 // management data drive value
  output logic mdio_oe_n_o,            // low while driving mdio
  input wire logic strap_fast_fd_i,    // strap: 100 full duplex
  input wire logic strap_fast_hd_i,    // strap: 100 half duplex
  input wire logic strap_ten_fd_i,     // strap: 10 full duplex
  input wire logic strap_ten_hd_i,     // strap: 10 half duplex
  input wire logic jabber_evt_i,       // jabber seen, one cycle pulse
  input wire logic an_complete_i,      // negotiation finished, level
  input wire logic full_duplex_i,      // resolved link is full duplex
  input wire logic lp_pause_i,         // partner symmetric pause
  input wire logic lp_asym_i,          // partner asymmetric pause
  output logic [15:0] adv_word_o,      // ability word for negotiation
  output logic pause_tx_o,             // resolved: send pause frames
  output logic pause_rx_o              // resolved: honour pause frames
);

  // synchronised pin inputs
  logic [5:0] pins_s;                  // synchroniser outputs
  logic mdc_s;                         // management clock, synced
  logic mdio_s;                        // management data, synced
  logic [3:0] strap_s;                 // straps, synced

  pia_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .async_i({strap_ten_hd_i, strap_ten_fd_i, strap_fast_hd_i,
              strap_fast_fd_i, mdio_i, mdc_i}),
    .sync_o(pins_s)
  );

  assign mdc_s = pins_s[0];
  assign mdio_s = pins_s[1];
  assign strap_s = pins_s[5:2];

  // frame engine state
  pia_pkg::pia_state_t state;          // current frame phase
  pia_pkg::pia_state_t next_state;     // next frame phase
  logic mdc_d;                         // previous synced mdc
  logic [5:0] pre;                     // preamble ones seen, saturating
  logic [5:0] next_pre;                // next preamble count
  logic [4:0] cnt;                     // bit counter within a phase
  logic [4:0] next_cnt;                // next bit counter
  logic [1:0] op;                      // opcode shift
  logic [1:0] next_op;                 // next opcode
  logic [8:0] addr_sh;                 // phy and register address shift
  logic [8:0] next_addr_sh;            // next address shift
  logic [4:0] reg_sel;                 // register of current frame
  logic [4:0] next_reg_sel;            // next register select
  logic is_read;                       // current frame reads
  logic next_is_read;                  // next read flag
  logic [15:0] dat_sh;                 // read or write data shift
  logic [15:0] next_dat_sh;            // next data shift
  logic next_mdio;                     // next drive value
  logic next_oe_n;                     // next drive enable, low active
  logic rd_take;                       // read snapshot taken this cycle
  logic wr_take;                       // write data complete this cycle

  // register contents
  logic jabber_seen;                   // latched jabber flag
  logic strap_pend;                    // straps still to be loaded
  logic next_page_wish;                // advert bit 15
  logic far_fault_advert;              // advert bit 13
  logic asym_pause_advert;             // advert bit 11
  logic pause_advert;                  // advert bit 10
  logic fast_full_duplex_advert;       // advert bit 8
  logic fast_half_advert;              // advert bit 7
  logic ten_full_duplex_advert;        // advert bit 6
  logic ten_half_advert;               // advert bit 5
  logic [4:0] selector;                // advert bits 4:0

  // decoding wires
  logic rise;                          // mdc rising edge seen
  logic [9:0] addr_full;               // address incl. current bit
  logic phy_hit;                       // frame is for this device
  logic [15:0] wr_data;                // completed write word
  logic [15:0] basic_status_reg;       // read view of basic status
  logic [15:0] ident_word_one;         // read view of ident one
  logic [15:0] ident_word_two;         // read view of ident two
  logic [15:0] ability_advert_reg;     // read view of advertisement
  logic [15:0] phy_control_reg;        // read view of phy control
  logic [15:0] rd_value;               // selected read word
  logic clr_jabber;                    // read of basic status
  logic wr_advert;                     // write to advertisement
  logic res_both;                      // both ends symmetric pause
  logic res_tx;                        // resolution: transmit pause
  logic res_rx;                        // resolution: receive pause

  assign rise = mdc_s & ~mdc_d;
  assign addr_full = {addr_sh, mdio_s};
  assign phy_hit = (addr_full[9:5] == `PIA_PHY_ADDR);
  assign wr_data = {dat_sh[14:0], mdio_s};

  // read views; reserved and unimplemented bits read zero
  assign basic_status_reg = {10'h000, an_complete_i, 3'h0,
                             jabber_seen,
                             1'b1};
  assign ident_word_one = ORG_HIGH;
  assign ident_word_two = {ORG_LOW,
                           MODEL,
                           REV};
  assign ability_advert_reg = {next_page_wish,
                               1'b0,
                               far_fault_advert,
                               1'b0,
                               asym_pause_advert,
                               pause_advert,
                               1'b0,
                               fast_full_duplex_advert,
                               fast_half_advert,
                               ten_full_duplex_advert,
                               ten_half_advert,
                               selector};
  assign phy_control_reg = {2'h0, pause_tx_o, pause_rx_o, 12'h000};

  // register select; unmapped registers read zero
  assign rd_value = (reg_sel == `PIA_REG_BASIC_STATUS) ? basic_status_reg :
                    (reg_sel == `PIA_REG_IDENT_HIGH) ? ident_word_one :
                    (reg_sel == `PIA_REG_IDENT_LOW) ? ident_word_two :
                    (reg_sel == `PIA_REG_ADVERT) ? ability_advert_reg :
                    (reg_sel == `PIA_REG_PHY_CONTROL) ? phy_control_reg :
                    16'h0000;

  // a read clears jabber only once the word is snapshotted
  assign clr_jabber = rd_take & (reg_sel == `PIA_REG_BASIC_STATUS);
  assign wr_advert = wr_take & (reg_sel == `PIA_REG_ADVERT);

  // pause resolution, full duplex links after negotiation only
  assign res_both = pause_advert & lp_pause_i;
  assign res_tx = res_both | (~pause_advert & asym_pause_advert & lp_pause_i & lp_asym_i);
  assign res_rx = res_both | (pause_advert & asym_pause_advert & ~lp_pause_i & lp_asym_i);

  // frame engine next state; every step happens on an mdc rising edge
  always_comb begin
    next_state = state;
    next_pre = pre;
    next_cnt = cnt;
    next_op = op;
    next_addr_sh = addr_sh;
    next_reg_sel = reg_sel;
    next_is_read = is_read;
    next_dat_sh = dat_sh;
    next_mdio = mdio_o;
    next_oe_n = mdio_oe_n_o;
    rd_take = 1'b0;
    wr_take = 1'b0;
    if (rise) begin
      case (state)
        pia_pkg::ST_IDLE: begin
          // hunt a full preamble, then the zero of the start pattern
          if (mdio_s) begin
            if (pre != `PIA_PREAMBLE_ONES) begin
              next_pre = pre + 6'h01;
            end
          end else if (pre == `PIA_PREAMBLE_ONES) begin
            next_state = pia_pkg::ST_START;
          end else begin
            next_pre = 6'h00;
          end
        end
        pia_pkg::ST_START: begin
          // second start bit must be one
          next_pre = 6'h00;
          next_cnt = 5'h00;
          next_state = mdio_s ? pia_pkg::ST_OPCODE : pia_pkg::ST_IDLE;
        end
        pia_pkg::ST_OPCODE: begin
          next_op = {op[0], mdio_s};
          next_cnt = cnt + 5'h01;
          if (cnt == 5'h01) begin
            next_cnt = 5'h00;
            next_state = pia_pkg::ST_ADDR;
          end
        end
        pia_pkg::ST_ADDR: begin
          next_addr_sh = addr_full[8:0];
          next_cnt = cnt + 5'h01;
          if (cnt == (`PIA_ADDR_BITS - 5'h01)) begin
            // other devices' frames and bad opcodes are left alone
            next_cnt = 5'h00;
            next_reg_sel = addr_full[4:0];
            next_is_read = (op == `PIA_OP_READ);
            if (phy_hit && (op == `PIA_OP_READ || op == `PIA_OP_WRITE)) begin
              next_state = pia_pkg::ST_TURN;
            end else begin
              next_state = pia_pkg::ST_IDLE;
            end
          end
        end
        pia_pkg::ST_TURN: begin
          // first turnaround bit is the master's release
          next_cnt = cnt + 5'h01;
          if (is_read && cnt == 5'h00) begin
            next_mdio = 1'b0;
            next_oe_n = 1'b0;
          end
          if (cnt == 5'h01) begin
            next_cnt = 5'h00;
            next_state = pia_pkg::ST_DATA;
            if (is_read) begin
              rd_take = 1'b1;
              next_dat_sh = {rd_value[14:0], 1'b0};
              next_mdio = rd_value[15];
            end
          end
        end
        pia_pkg::ST_DATA: begin
          next_cnt = cnt + 5'h01;
          if (is_read) begin
            next_mdio = dat_sh[15];
            next_dat_sh = {dat_sh[14:0], 1'b0};
          end else begin
            next_dat_sh = wr_data;
          end
          if (cnt == `PIA_DATA_LAST) begin
            // last bit: release the line and commit a write
            wr_take = ~is_read;
            next_mdio = 1'b0;
            next_oe_n = 1'b1;
            next_cnt = 5'h00;
            next_state = pia_pkg::ST_IDLE;
          end
        end
        default: begin
          next_state = pia_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // frame engine registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= pia_pkg::ST_IDLE;
      mdc_d <= 1'b0;
      pre <= 6'h00;
      cnt <= 5'h00;
      op <= 2'h0;
      addr_sh <= 9'h000;
      reg_sel <= 5'h00;
      is_read <= 1'b0;
      dat_sh <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe_n_o <= 1'b1;
    end else begin
      state <= next_state;
      mdc_d <= mdc_s;
      pre <= next_pre;
      cnt <= next_cnt;
      op <= next_op;
      addr_sh <= next_addr_sh;
      reg_sel <= next_reg_sel;
      is_read <= next_is_read;
      dat_sh <= next_dat_sh;
      mdio_o <= next_mdio;
      mdio_oe_n_o <= next_oe_n;
    end
  end

  // jabber latch; a new event wins over a clearing read
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      jabber_seen <= 1'b0;
    end else begin
      jabber_seen <= jabber_evt_i | (jabber_seen & ~clr_jabber);
    end
  end

  // advertisement register; straps load on the first cycle after reset
  // so that the synchronised strap levels are used, not the raw pins
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      strap_pend <= 1'b1;
      next_page_wish <= 1'b0;
      far_fault_advert <= 1'b0;
      asym_pause_advert <= 1'b0;
      pause_advert <= 1'b0;
      fast_full_duplex_advert <= 1'b0;
      fast_half_advert <= 1'b0;
      ten_full_duplex_advert <= 1'b0;
      ten_half_advert <= 1'b0;
      selector <= `PIA_SELECTOR_RST;
    end else if (strap_pend) begin
      strap_pend <= 1'b0;
      fast_full_duplex_advert <= strap_s[0];
      fast_half_advert <= strap_s[1];
      ten_full_duplex_advert <= strap_s[2];
      ten_half_advert <= strap_s[3];
    end else if (wr_advert) begin
      // bits 14, 12 and 9 have no storage, written values vanish
      next_page_wish <= wr_data[`PIA_AD_NEXT_PAGE];
      far_fault_advert <= wr_data[`PIA_AD_FAR_FAULT];
      asym_pause_advert <= wr_data[`PIA_AD_ASYM];
      pause_advert <= wr_data[`PIA_AD_PAUSE];
      fast_full_duplex_advert <= wr_data[`PIA_AD_FAST_FD];
      fast_half_advert <= wr_data[`PIA_AD_FAST_HD];
      ten_full_duplex_advert <= wr_data[`PIA_AD_TEN_FD];
      ten_half_advert <= wr_data[`PIA_AD_TEN_HD];
      selector <= wr_data[`PIA_AD_SEL_HI:0];
    end
  end

  // outputs toward negotiation and the mac; the word changes only on
  // the strap load after reset or a write, the controller restarts negotiation when it needs it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      adv_word_o <= 16'h0000;
      pause_tx_o <= 1'b0;
      pause_rx_o <= 1'b0;
    end else begin
      adv_word_o <= ability_advert_reg;
      pause_tx_o <= an_complete_i & full_duplex_i & res_tx;
      pause_rx_o <= an_complete_i & full_duplex_i & res_rx;
    end
  end

endmodule

// ---- sim/pia_mdio_master.sv ----
`include "pia_defines.svh"
// station management controller on the far side of the management pins
module pia_mdio_master (
  input wire logic clk_sys_i,    // system clock
  input wire logic mdio_i,       // resolved data line
  output logic mdc_o,            // management clock
  output logic mdio_o,           // drive value
  output logic mdio_en_o,        // high while driving
  output logic rd_valid_o,       // read word ready, one cycle
  output logic [15:0] rd_data_o  // read word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_en_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 16'h0000;
  end
  // one bit cell: data changes while mdc low, sampled at the rise
  task automatic bit_cell(input logic en, input logic b, output logic s);
    @(negedge clk_sys_i);
    mdc_o = 1'b0;
    mdio_en_o = en;
    mdio_o = b;
    repeat (4) @(negedge clk_sys_i);
    s = mdio_i;
    mdc_o = 1'b1;
    repeat (3) @(negedge clk_sys_i);
  endtask
  // whole frame, always with a full preamble
  task automatic xfer(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] rg,
                      input logic [15:0] wd);
    logic [63:0] frm;
    logic s;
    frm = {32'hffff_ffff, 2'b01, op, phy, rg, 2'b10, wd};
    if (rg == `PIA_REG_ADVERT) frm[12] = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      // line released from the first turnaround bit of a read
      bit_cell(op == `PIA_OP_WRITE || i > 17, frm[i], s);
      if (i < 16) rd_data_o[i] = s;
    end
    @(negedge clk_sys_i);
    mdc_o = 1'b0; // clock stands still between frames
    mdio_en_o = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    rd_valid_o = (op == `PIA_OP_READ);
    @(negedge clk_sys_i);
    rd_valid_o = 1'b0;
  endtask
endmodule

// ---- sim/pia_regs_properties.sv ----
// port-level checks of the register block
module pia_regs_properties (
  input wire logic clk_sys_i,       // system clock
  input wire logic rst_i,           // sync reset
  input wire logic mdc_i,           // mgmt clock pin
  input wire logic mdio_i,          // mgmt data line
  input wire logic mdio_o,          // device drive value
  input wire logic mdio_oe_n_o,     // low while driving
  input wire logic strap_fast_fd_i, // strap
  input wire logic strap_fast_hd_i, // strap
  input wire logic strap_ten_fd_i,  // strap
  input wire logic strap_ten_hd_i,  // strap
  input wire logic jabber_evt_i,    // jabber pulse
  input wire logic an_complete_i,   // negotiation done
  input wire logic full_duplex_i,   // duplex
  input wire logic lp_pause_i,      // partner pause
  input wire logic lp_asym_i,       // partner asym
  input wire logic [15:0] adv_word_o, // advert copy
  input wire logic pause_tx_o,      // resolved tx pause
  input wire logic pause_rx_o       // resolved rx pause
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic mdc_prev; // last mdc level
  logic [4:0] drive_rises; // mdc rises while device drives
  wire [3:0] link_in = {an_complete_i, full_duplex_i, lp_pause_i, lp_asym_i};
  wire link_ok = an_complete_i && full_duplex_i;
  wire lp = adv_word_o[10];
  wire la = adv_word_o[11];
  wire both = lp && lp_pause_i;
  wire want_tx = link_ok && (both || (!lp && la && lp_pause_i && lp_asym_i));
  wire want_rx = link_ok && (both || (lp && la && !lp_pause_i && lp_asym_i));
  // counts bit cells of one driven word; cleared whenever released
  always_ff @(posedge clk_sys_i) begin
    mdc_prev <= mdc_i;
    if (rst_i || mdio_oe_n_o) drive_rises <= 5'h00;
    else if (mdc_i && !mdc_prev) drive_rises <= drive_rises + 5'h01;
  end
  a_pause_tx_res: assert property (
    !$past(rst_i) && $stable(link_in) |-> pause_tx_o == want_tx)
    else $error("pause transmit resolution differs");
  a_pause_rx_res: assert property (
    !$past(rst_i) && $stable(link_in) |-> pause_rx_o == want_rx)
    else $error("pause receive resolution differs");
  a_pause_no_link: assert property (
    !$past(link_ok) |-> !pause_tx_o && !pause_rx_o)
    else $error("pause resolved without full duplex link");
  a_rsvd_bits_zero: assert property (!adv_word_o[14] && !adv_word_o[12])
    else $error("reserved advert bit set");
  a_four_pair_zero: assert property (adv_word_o[9] == 1'b0)
    else $error("four pair ability advertised");
  a_strap_load: assert property ($fell(rst_i) |-> ##2
    adv_word_o == {7'h00, strap_fast_fd_i, strap_fast_hd_i, strap_ten_fd_i, strap_ten_hd_i, 5'h01})
    else $error("advert reset value wrong");
  a_drive_word_len: assert property (
    $rose(mdio_oe_n_o) && !$past(rst_i) |-> drive_rises == 5'h11)
    else $error("driven word length wrong");
  a_advert_quiet: assert property (
    !$past(rst_i) && !$past(rst_i, 2) && $changed(adv_word_o) |-> mdio_oe_n_o)
    else $error("advert changed during a read");
  c_read_done: cover property ($rose(mdio_oe_n_o));
  c_tx_only: cover property (pause_tx_o && !pause_rx_o);
  c_rx_only: cover property (pause_rx_o && !pause_tx_o);
endmodule

bind pia_regs pia_regs_properties u_pia_regs_properties (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o),
  .mdio_oe_n_o(mdio_oe_n_o), .strap_fast_fd_i(strap_fast_fd_i),
  .strap_fast_hd_i(strap_fast_hd_i), .strap_ten_fd_i(strap_ten_fd_i),
  .strap_ten_hd_i(strap_ten_hd_i), .jabber_evt_i(jabber_evt_i), .an_complete_i(an_complete_i),
  .full_duplex_i(full_duplex_i), .lp_pause_i(lp_pause_i), .lp_asym_i(lp_asym_i),
  .adv_word_o(adv_word_o), .pause_tx_o(pause_tx_o), .pause_rx_o(pause_rx_o));

// ---- sim/testbench.sv ----
`include "pia_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ORG_HIGH = 16'h4c5b; // arbitrary value
  localparam logic [5:0] ORG_LOW = 6'h2d; // arbitrary value
  localparam logic [5:0] MODEL = 6'h13; // arbitrary value
  localparam logic [3:0] REV = 4'h6; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] straps = 4'h0;
  logic jab = 1'b0;
  logic an = 1'b0;
  logic fd = 1'b0;
  logic lpp = 1'b0;
  logic lpa = 1'b0;
  wire mdc, m_val, m_en, rd_valid, mdio_q, oe_n, p_tx, p_rx;
  wire [15:0] rd_data, adv;
  wire mdio_line = !oe_n ? mdio_q : (m_en ? m_val : 1'b1); // pull-up when idle
  logic [15:0] exp_q[$]; // expected read words, oldest first
  int n_errors = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  pia_regs #(.ORG_HIGH(ORG_HIGH), .ORG_LOW(ORG_LOW), .MODEL(MODEL), .REV(REV)) u_pia_regs (
    .clk_sys_i(clk), .rst_i(rst), .mdc_i(mdc), .mdio_i(mdio_line), .mdio_o(mdio_q),
    .mdio_oe_n_o(oe_n), .strap_fast_fd_i(straps[3]), .strap_fast_hd_i(straps[2]),
    .strap_ten_fd_i(straps[1]), .strap_ten_hd_i(straps[0]), .jabber_evt_i(jab),
    .an_complete_i(an), .full_duplex_i(fd), .lp_pause_i(lpp), .lp_asym_i(lpa),
    .adv_word_o(adv), .pause_tx_o(p_tx), .pause_rx_o(p_rx));
  pia_mdio_master u_pia_mdio_master (.clk_sys_i(clk), .mdio_i(mdio_line), .mdc_o(mdc),
    .mdio_o(m_val), .mdio_en_o(m_en), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rd(input logic [4:0] rg, input logic [15:0] exp,
                    input logic [4:0] phy = `PIA_PHY_ADDR);
    exp_q.push_back(exp);
    u_pia_mdio_master.xfer(phy, `PIA_OP_READ, rg, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    u_pia_mdio_master.xfer(`PIA_PHY_ADDR, `PIA_OP_WRITE, rg, d);
  endtask
  // expected {tx, rx} pause for local {asym, pause} and present link inputs
  function automatic logic [1:0] pause_exp(input logic [1:0] l);
    logic both;
    both = l[0] && lpp;
    return {2{an && fd}} & {both || (!l[0] && l[1] && lpp && lpa),
                            both || (l[0] && l[1] && !lpp && lpa)};
  endfunction
  // result watcher: each returned word meets the oldest note
  always @(posedge rd_valid) check(rd_data, exp_q.pop_front());
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    logic [15:0] v;
    void'($urandom(32'h98af));
    straps = 4'($urandom);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    v = {7'h00, straps, 5'h01};
    check(adv, v);
    rd(`PIA_REG_ADVERT, v);
    rd(`PIA_REG_BASIC_STATUS, 16'h0001);
    jab = 1'b1;
    @(negedge clk);
    jab = 1'b0;
    an = 1'b1; // all advert writes below follow completion
    rd(`PIA_REG_BASIC_STATUS, 16'h0023);
    rd(`PIA_REG_BASIC_STATUS, 16'h0021);
    wr(`PIA_REG_IDENT_HIGH, ~ORG_HIGH);
    wr(`PIA_REG_IDENT_LOW, 16'h0000);
    rd(`PIA_REG_IDENT_HIGH, ORG_HIGH);
    rd(`PIA_REG_IDENT_LOW, {ORG_LOW, MODEL, REV});
    rd(5'h05, 16'h0000); // unmapped index reads zero
    rd(`PIA_REG_IDENT_HIGH, 16'hffff, 5'h02); // other address: line stays pulled up
    // a frame with an illegal opcode must leave the advert alone
    u_pia_mdio_master.xfer(`PIA_PHY_ADDR, 2'b00, `PIA_REG_ADVERT, 16'h0000);
    rd(`PIA_REG_ADVERT, v);
    wr(`PIA_REG_ADVERT, 16'hffff);
    rd(`PIA_REG_ADVERT, 16'hadff);
    repeat (4) begin
      v = 16'($urandom);
      wr(`PIA_REG_ADVERT, v);
      check(adv, v & 16'hadff);
      rd(`PIA_REG_ADVERT, v & 16'hadff);
    end
    for (int l = 0; l < 4; l++) begin
      wr(`PIA_REG_ADVERT, {4'h0, 2'(l), 10'h000});
      for (int r = 0; r < 8; r++) begin
        {fd, lpa, lpp} = 3'(r);
        repeat (3) @(negedge clk);
        check({14'h0000, p_tx, p_rx}, {14'h0000, pause_exp(2'(l))});
      end
      rd(`PIA_REG_PHY_CONTROL, {2'b00, pause_exp(2'(l)), 12'h000});
    end
    an = 1'b0;
    repeat (3) @(negedge clk);
    check({14'h0000, p_tx, p_rx}, 16'h0000);
    repeat (10) @(negedge clk);
    report_and_stop();
  end
endmodule
